// ### rtl/opmc_map.svh
// Command codes, field positions, reset values for output enable control
`ifndef OPMC_MAP_SVH
`define OPMC_MAP_SVH

// Command codes of the two byte-wide settings
`define OPMC_CMD_RUN      8'h01
`define OPMC_CMD_CFG      8'h02

// Run-control byte field positions
`define OPMC_EN_HI        7
`define OPMC_EN_LO        6
`define OPMC_MG_HI        5
`define OPMC_MG_LO        4
`define OPMC_FT_HI        3
`define OPMC_FT_LO        2

// Power-on configuration byte bit positions
`define OPMC_CFG_PWRUP    4
`define OPMC_CFG_BUS      3
`define OPMC_CFG_PIN      2
`define OPMC_CFG_POL      1
`define OPMC_CFG_FAST     0

// Values held until the power-up restore arrives
`define OPMC_RUN_RST      8'h08
`define OPMC_CFG_RST      8'h17

`endif

// ### rtl/opmc_mode_latch.sv
// Decoded operating mode that only legal field codes may change
`timescale 1ns/100ps
`include "opmc_map.svh"
module opmc_mode_latch
(
  // Clock and reset
  input  wire logic                sys_clk,
  input  wire logic                reset,
  // Run-control byte and its load strobe
  input  wire logic                load,
  input  wire logic [7:0]          run_byte,
  // Decoded mode
  output opmc_pkg::opmc_mode_s     mode
);
  import opmc_pkg::*;

  opmc_mode_s next_mode;

  function automatic logic code_ok(input logic [1:0] code,
                                   input logic       zero_ok);
    code_ok = (code != 2'b11) && (zero_ok || code != 2'b00);
  endfunction

  always_comb
  begin
    next_mode = mode;
    if (load)
    begin
      // Undefined codes leave the previous state in force
      if (code_ok(run_byte[`OPMC_EN_HI:`OPMC_EN_LO], 1'b1)) // [RQ19]
        next_mode.en = opmc_en_e'(run_byte[`OPMC_EN_HI:`OPMC_EN_LO]);
      if (code_ok(run_byte[`OPMC_MG_HI:`OPMC_MG_LO], 1'b1)) // [RQ19]
        next_mode.mg = opmc_mg_e'(run_byte[`OPMC_MG_HI:`OPMC_MG_LO]);
      if (code_ok(run_byte[`OPMC_FT_HI:`OPMC_FT_LO], 1'b0)) // [RQ19]
        next_mode.ft = opmc_ft_e'(run_byte[`OPMC_FT_HI:`OPMC_FT_LO]);
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      mode.en <= OPMC_EN_IMM;
      mode.mg <= OPMC_MG_NOM;
      mode.ft <= OPMC_FT_ACT;
    end
    else
      mode <= next_mode;
  end
endmodule // opmc_mode_latch

// ### rtl/opmc_pkg.sv
// Types shared by the output enable and margin control block
package opmc_pkg;

  typedef enum logic [1:0] {
    OPMC_EN_IMM  = 2'b00,
    OPMC_EN_SOFT = 2'b01,
    OPMC_EN_ON   = 2'b10
  } opmc_en_e;

  typedef enum logic [1:0] {
    OPMC_MG_NOM  = 2'b00,
    OPMC_MG_LOW  = 2'b01,
    OPMC_MG_HIGH = 2'b10
  } opmc_mg_e;

  typedef enum logic [1:0] {
    OPMC_FT_IGNORE = 2'b01,
    OPMC_FT_ACT    = 2'b10
  } opmc_ft_e;

  typedef enum logic [1:0] {
    OPMC_ST_OFF  = 2'b00,
    OPMC_ST_RUN  = 2'b01,
    OPMC_ST_SOFT = 2'b10
  } opmc_state_e;

  typedef struct packed {
    opmc_en_e en;
    opmc_mg_e mg;
    opmc_ft_e ft;
  } opmc_mode_s;

  typedef struct packed {
    logic ov_warn;
    logic ov_fault;
    logic uv_warn;
    logic uv_fault;
  } opmc_vout_evt_s;

  typedef struct packed {
    logic       valid;
    logic [7:0] run_byte;
    logic [7:0] cfg_byte;
  } opmc_restore_s;

endpackage

// ### rtl/opmc_sync.sv
// Two-flop synchronisers for the enable pin and the input power sense
`timescale 1ns/100ps
module opmc_sync
(
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       reset,
  // Asynchronous levels in, synchronised levels out
  input  wire logic [1:0] async_in,
  output logic      [1:0] sync_out
);
  logic [1:0] meta;
  logic [1:0] next_meta;
  logic [1:0] next_sync;

  genvar i;
  generate
    for (i = 0; i < 2; i++)
    begin : g_bit
      always_comb
      begin
        next_meta[i] = async_in[i];
        next_sync[i] = meta[i];
      end
    end
  endgenerate

  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      meta     <= 2'h0;
      sync_out <= 2'h0;
    end
    else
    begin
      meta     <= next_meta;
      sync_out <= next_sync;
    end
  end
endmodule // opmc_sync

// ### rtl/opmc_top.sv
// Output enable, shutdown style and margin target control
//
// Function
// [RQ1] Enable 00: immediate shutdown, no sequencing
// [RQ2] Enable 01: soft shutdown through turn-off sequence
// [RQ3] Enable 10: run at selected margin target
// [RQ4] Margin 00: regulate to nominal target
// [RQ5] Margin 01: regulate to margin-low target
// [RQ6] Margin 10: regulate to margin-high target
// [RQ7] Fault field: 10 acts, 01 ignores
// [RQ8] Ignore while margined: suppress output voltage events
// [RQ9] Act while margined: pass output voltage events
// [RQ10] Power-up bit clear: run whenever power present
// [RQ11] Power-up bit set: wait for pin and command
// [RQ12] Bus-mode bit clear: ignore command on/off field
// [RQ13] Bus-mode bit set: command must say run
// [RQ14] Pin-mode bit clear: ignore enable pin
// [RQ15] Pin-mode bit set: enable pin must assert
// [RQ16] Polarity bit: 0 low asserts, 1 high
// [RQ17] Disable bit clear: pin off uses soft sequence
// [RQ18] Disable bit set: pin off stops energy fast
// [RQ19] Undefined field codes hold previous operating state
`timescale 1ns/100ps
`include "opmc_map.svh"
module opmc_top
(
  // Clock and reset
  input  wire logic                   sys_clk,
  input  wire logic                   reset,
  // Command register port from the serial bus layer
  input  wire logic [7:0]             cmd_code,
  input  wire logic                   wr_req,
  input  wire logic [7:0]             wr_data,
  input  wire logic                   rd_req,
  output logic      [7:0]             rd_data,
  output logic                        cmd_ack,
  output logic                        cmd_nack,
  // Settings restored from storage at power-up
  input  wire opmc_pkg::opmc_restore_s restore,
  // Pins
  input  wire logic                   enable_pin,
  input  wire logic                   power_present,
  // Converter status
  input  wire logic                   toff_done,
  input  wire opmc_pkg::opmc_vout_evt_s vout_evt_in,
  // Sequencer control
  output logic                        out_run,
  output logic                        soft_off_active,
  output logic                        toff_start,
  output logic                        fast_off,
  // Margin target and fault gating
  output opmc_pkg::opmc_mg_e          target_sel,
  output logic                        vout_fault_act,
  output opmc_pkg::opmc_vout_evt_s    vout_evt_out
);
  import opmc_pkg::*;

  // Register and mode state
  logic [7:0]     run_byte;
  logic [7:0]     cfg_byte;
  logic [7:0]     next_run_byte;
  logic [7:0]     next_cfg_byte;
  logic           mode_load;
  logic [7:0]     mode_src;
  opmc_mode_s     mode;

  // Synchronised pin levels
  logic [1:0]     pins_sync;
  logic           pin_level;
  logic           pwr_ok;

  // Enable decision
  logic           gate_bus;
  logic           gate_pin;
  logic           bus_on;
  logic           pin_on;
  logic           want_on;
  logic           off_now;
  logic           bus_imm;
  logic           pin_fast;

  // Sequencer state
  opmc_state_e    state;
  opmc_state_e    next_state;
  logic           next_out_run;
  logic           next_soft_off_active;
  logic           next_toff_start;
  logic           next_fast_off;

  // Margin and fault gating
  logic           margined;
  logic           suppress;
  opmc_mg_e       next_target_sel;
  logic           next_vout_fault_act;
  opmc_vout_evt_s next_vout_evt_out;

  // Bus answer
  logic [7:0]     next_rd_data;
  logic           next_cmd_ack;
  logic           next_cmd_nack;

  // Command decode
  logic           hit_run;
  logic           hit_cfg;

  // Bit 0 carries the enable pin, bit 1 the input power sense
  opmc_sync u_sync
  (
    .sys_clk  (sys_clk),
    .reset    (reset),
    .async_in ({power_present, enable_pin}),
    .sync_out (pins_sync)
  );

  assign pin_level = pins_sync[0];
  assign pwr_ok    = pins_sync[1];

  // A source only gates start-up once the power-up bit hands over control
  function automatic logic src_used(input logic [7:0] cfg,
                                    input logic       sel);
    src_used = cfg[`OPMC_CFG_PWRUP] && sel;             // [RQ10] [RQ11]
  endfunction

  // Command decode, shared by the write path and the answer
  always_comb
  begin
    hit_run = (cmd_code == `OPMC_CMD_RUN);
    hit_cfg = (cmd_code == `OPMC_CMD_CFG);
  end

  // Register writes; the power-up restore overrides a host write
  always_comb
  begin
    next_run_byte = run_byte;
    next_cfg_byte = cfg_byte;
    if (restore.valid)
    begin
      next_run_byte = restore.run_byte;
      next_cfg_byte = restore.cfg_byte;
    end
    else if (wr_req && hit_run)
      next_run_byte = wr_data;
    else if (wr_req && hit_cfg)
      next_cfg_byte = wr_data;
  end

  // Restore and host write share one mode decoder
  assign mode_load = restore.valid || (wr_req && hit_run);
  assign mode_src  = restore.valid ? restore.run_byte : wr_data;

  opmc_mode_latch u_mode
  (
    .sys_clk  (sys_clk),
    .reset    (reset),
    .load     (mode_load),
    .run_byte (mode_src),
    .mode     (mode)
  );

  // Register read and command answer, one cycle after the request
  always_comb
  begin
    next_rd_data  = 8'h00;
    next_cmd_ack  = 1'b0;
    next_cmd_nack = 1'b0;
    if (rd_req || wr_req)
    begin
      if (hit_run)
      begin
        next_cmd_ack = 1'b1;
        if (rd_req)
          next_rd_data = run_byte;
      end
      else if (hit_cfg)
      begin
        next_cmd_ack = 1'b1;
        if (rd_req)
          next_rd_data = cfg_byte;
      end
      else
      begin
        // Refused codes change no register
        next_cmd_nack = 1'b1;
      end
    end
  end

  // Enable sources
  always_comb
  begin
    // Power-up bit clear lets the output run on power alone
    gate_bus = src_used(cfg_byte, cfg_byte[`OPMC_CFG_BUS]); // [RQ12] [RQ13]
    gate_pin = src_used(cfg_byte, cfg_byte[`OPMC_CFG_PIN]); // [RQ14] [RQ15]
    bus_on   = (mode.en == OPMC_EN_ON);                 // [RQ3]
    pin_on   = (pin_level == cfg_byte[`OPMC_CFG_POL]);  // [RQ16]
    want_on  = pwr_ok
               && (!gate_bus || bus_on)                 // [RQ13]
               && (!gate_pin || pin_on);                // [RQ15]
    // Fast sources: bus immediate off and pin release with fast bit
    bus_imm  = gate_bus && (mode.en == OPMC_EN_IMM);    // [RQ1]
    pin_fast = gate_pin && !pin_on
               && cfg_byte[`OPMC_CFG_FAST];             // [RQ18]
    // Power loss counts as immediate; any fast source wins over a soft one
    off_now  = !pwr_ok || bus_imm || pin_fast;
  end

  // Run, soft-off and off sequencing
  always_comb
  begin
    next_state      = state;
    next_toff_start = 1'b0;
    next_fast_off   = 1'b0;
    case (state)
      OPMC_ST_OFF:
      begin
        // Start only once every enabled source agrees
        if (want_on)
          next_state = OPMC_ST_RUN;
      end
      OPMC_ST_RUN:
      begin
        // Fast exit is checked first so it never waits on the timer
        if (!want_on && off_now)
        begin
          next_state    = OPMC_ST_OFF;
          next_fast_off = 1'b1;                         // [RQ1] [RQ18]
        end
        else if (!want_on)
        begin
          next_state      = OPMC_ST_SOFT;
          next_toff_start = 1'b1;                       // [RQ2] [RQ17]
        end
      end
      OPMC_ST_SOFT:
      begin
        // An immediate request cuts a running soft shutdown short
        if (off_now)
        begin
          next_state    = OPMC_ST_OFF;
          next_fast_off = 1'b1;                         // [RQ1]
        end
        else if (toff_done)
          next_state = OPMC_ST_OFF;                     // [RQ2] [RQ17]
      end
      default:
        next_state = OPMC_ST_OFF;
    endcase
    next_out_run         = (next_state == OPMC_ST_RUN);
    next_soft_off_active = (next_state == OPMC_ST_SOFT);
  end

  // Margin target and fault gating
  always_comb
  begin
    next_target_sel     = mode.mg;                      // [RQ4] [RQ5] [RQ6]
    margined            = (mode.mg != OPMC_MG_NOM);
    // Outside margining the events always pass
    suppress            = margined
                          && (mode.ft == OPMC_FT_IGNORE); // [RQ7] [RQ8]
    if (suppress)
    begin
      next_vout_fault_act = 1'b0;                       // [RQ8]
      next_vout_evt_out   = '0;                         // [RQ8]
    end
    else
    begin
      next_vout_fault_act = 1'b1;                       // [RQ9]
      next_vout_evt_out   = vout_evt_in;                // [RQ9]
    end
  end

  // Register group
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      run_byte <= `OPMC_RUN_RST;
      cfg_byte <= `OPMC_CFG_RST;
    end
    else
    begin
      run_byte <= next_run_byte;
      cfg_byte <= next_cfg_byte;
    end
  end

  // Sequencer group
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      state           <= OPMC_ST_OFF;
      out_run         <= 1'b0;
      soft_off_active <= 1'b0;
      toff_start      <= 1'b0;
      fast_off        <= 1'b0;
    end
    else
    begin
      state           <= next_state;
      out_run         <= next_out_run;
      soft_off_active <= next_soft_off_active;
      toff_start      <= next_toff_start;
      fast_off        <= next_fast_off;
    end
  end

  // Margin target and fault gating group
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      target_sel     <= OPMC_MG_NOM;
      vout_fault_act <= 1'b1;
      vout_evt_out   <= '0;
    end
    else
    begin
      target_sel     <= next_target_sel;
      vout_fault_act <= next_vout_fault_act;
      vout_evt_out   <= next_vout_evt_out;
    end
  end

  // Bus answer group
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      rd_data  <= 8'h00;
      cmd_ack  <= 1'b0;
      cmd_nack <= 1'b0;
    end
    else
    begin
      rd_data  <= next_rd_data;
      cmd_ack  <= next_cmd_ack;
      cmd_nack <= next_cmd_nack;
    end
  end
endmodule // opmc_top

// ### verification/opmc_checker.sv
// Assertion checker for the output enable and margin block
`timescale 1ns/100ps
module opmc_checker
(
  // Clock and reset
  input  wire logic                     sys_clk,
  input  wire logic                     reset,
  // Register port
  input  wire logic [7:0]               cmd_code,
  input  wire logic                     wr_req,
  input  wire logic                     rd_req,
  input  wire logic                     cmd_ack,
  input  wire logic                     cmd_nack,
  // Converter side
  input  wire logic                     power_present,
  input  wire opmc_pkg::opmc_vout_evt_s vout_evt_in,
  input  wire logic                     out_run,
  input  wire logic                     soft_off_active,
  input  wire logic                     toff_start,
  input  wire logic                     fast_off,
  input  wire opmc_pkg::opmc_mg_e       target_sel,
  input  wire logic                     vout_fault_act,
  input  wire opmc_pkg::opmc_vout_evt_s vout_evt_out
);
  import opmc_pkg::*;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  logic req;
  logic known;
  assign req   = wr_req | rd_req;
  assign known = cmd_code == 8'h01 || cmd_code == 8'h02;

  ack_known_a: assert property (
    req && known |=> cmd_ack && !cmd_nack) else $error("no ack");
  nack_other_a: assert property (
    req && !known |=> cmd_nack && !cmd_ack) else $error("no nack");
  imm_off_a: assert property (
    fast_off |-> !out_run && !soft_off_active) else $error("fast off");
  soft_seq_a: assert property (
    toff_start |-> soft_off_active && !out_run ##1 !toff_start)
    else $error("soft off start");
  one_state_a: assert property (
    !(out_run && soft_off_active)) else $error("run and soft");
  target_legal_a: assert property (
    target_sel != 2'b11) else $error("bad target");
  fault_gate_a: assert property (
    !vout_fault_act |-> target_sel != OPMC_MG_NOM) else $error("gate");
  evt_mute_a: assert property (
    !vout_fault_act |-> vout_evt_out == 4'h0) else $error("not muted");
  evt_pass_a: assert property (
    vout_fault_act && !$past(reset) |-> vout_evt_out == $past(vout_evt_in))
    else $error("not passed");
  pwr_loss_a: assert property (
    !power_present [*3] |=> !out_run && !soft_off_active)
    else $error("runs without power");

  cover property (toff_start);
  cover property (fast_off);
  cover property (!vout_fault_act);
  cover property (target_sel == OPMC_MG_HIGH);
endmodule // opmc_checker

bind opmc_top opmc_checker u_chk (.sys_clk, .reset, .cmd_code, .wr_req,
  .rd_req, .cmd_ack, .cmd_nack, .power_present, .vout_evt_in, .out_run,
  .soft_off_active, .toff_start, .fast_off, .target_sel, .vout_fault_act,
  .vout_evt_out);

// ### verification/opmc_toff_model.sv
// Turn-off timer model answering a soft shutdown start
`timescale 1ns/100ps
module opmc_toff_model
#(
  parameter int DLY = 3
)
(
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic reset,
  // Answer speed and timer handshake
  input  wire logic slow,
  input  wire logic toff_start,
  output logic      toff_done
);
  int cnt;
  // A new start restarts the count, as a real timer would
  always @(posedge sys_clk)
  begin
    toff_done <= 1'b0;
    if (reset)
      cnt <= 0;
    else if (toff_start)
      cnt <= slow ? 4 * DLY : DLY;
    else if (cnt > 0)
    begin
      cnt <= cnt - 1;
      toff_done <= cnt == 1;
    end
  end
endmodule // opmc_toff_model

// ### verification/tb.sv
// Self-checking bench for the output enable and margin block
`timescale 1ns/100ps
module tb;
  import opmc_pkg::*;
  logic           sys_clk = 1'b0;
  logic           reset = 1'b1;
  logic [7:0]     cmd_code = 8'h00;
  logic           wr_req = 1'b0;
  logic [7:0]     wr_data = 8'h00;
  logic           rd_req = 1'b0;
  logic [7:0]     rd_data;
  logic           cmd_ack;
  logic           cmd_nack;
  opmc_restore_s  restore = '0;
  logic           enable_pin = 1'b0;
  logic           power_present = 1'b1;
  logic           toff_done;
  logic           slow = 1'b0;
  opmc_vout_evt_s vout_evt_in = '0;
  logic           out_run;
  logic           soft_off_active;
  logic           toff_start;
  logic           fast_off;
  opmc_mg_e       target_sel;
  logic           vout_fault_act;
  opmc_vout_evt_s vout_evt_out;
  logic [9:0]     expq[$];
  int             fail_count = 0;
  int             n_compared = 0;
  int             n_fast = 0;
  int             n_soft = 0;
  logic [31:0]    rng = 32'h61EC;
  logic           rnd_on = 1'b0;

  always #2.5 sys_clk = ~sys_clk;

  opmc_top uut (.sys_clk, .reset, .cmd_code, .wr_req, .wr_data, .rd_req,
    .rd_data, .cmd_ack, .cmd_nack, .restore, .enable_pin, .power_present,
    .toff_done, .vout_evt_in, .out_run, .soft_off_active, .toff_start,
    .fast_off, .target_sel, .vout_fault_act, .vout_evt_out);
  opmc_toff_model u_toff (.sys_clk, .reset, .slow, .toff_start,
    .toff_done);

  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction

  task automatic cmp_bus(input logic [9:0] got, input logic [9:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      fail_count++;
      $display("unexpected answer t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic cmp_out(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      fail_count++;
      $display("unexpected output t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  // Answer expected: {ack, nack, read data}
  task automatic acc(input logic w, input logic [7:0] c, input logic [7:0] d,
                     input logic [7:0] x);
    logic k;
    k = c == 8'h01 || c == 8'h02;
    expq.push_back({k, !k, x});
    @(posedge sys_clk);
    wr_req <= w;
    rd_req <= !w;
    cmd_code <= c;
    wr_data <= d;
    @(posedge sys_clk);
    wr_req <= 1'b0;
    rd_req <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] c, input logic [7:0] d);
    acc(1'b1, c, d, 8'h00);
  endtask

  task automatic rd(input logic [7:0] c, input logic [7:0] x);
    acc(1'b0, c, 8'h00, x);
  endtask

  // State word: {run, soft, target, fault acted}
  task automatic st(input int n, input logic [7:0] x);
    repeat (n) @(posedge sys_clk);
    #1;
    cmp_out({3'b000, out_run, soft_off_active, target_sel,
             vout_fault_act}, x);
  endtask

  task automatic stop_test;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  always @(posedge sys_clk)
    if (cmd_ack === 1'b1 || cmd_nack === 1'b1)
      cmp_bus({cmd_ack, cmd_nack, rd_data},
              expq.size() ? expq.pop_front() : 10'h3FF);

  always @(posedge sys_clk)
  begin
    n_fast += fast_off === 1'b1;
    n_soft += toff_start === 1'b1;
    if (rnd_on)
    begin
      rng = xs(rng);
      vout_evt_in <= rng[3:0];
    end
  end

  initial
  begin
    #50000;
    fail_count++;
    stop_test;
  end

  initial
  begin
    repeat (8) @(posedge sys_clk);
    reset <= 1'b0;
    rd(8'h01, 8'h08);
    rd(8'h02, 8'h17);
    rd(rng[7:0] | 8'h80, 8'h00);
    st(1, 8'h01);
    @(posedge sys_clk) restore <= '{1'b1, 8'h88, 8'h1E};
    @(posedge sys_clk) restore <= '0;
    rd(8'h02, 8'h1E);
    st(4, 8'h01);
    @(posedge sys_clk) enable_pin <= 1'b1;
    st(4, 8'h11);
    $display("test registers done");
    rnd_on <= 1'b1;
    for (int m = 0; m < 3; m++)
      for (int f = 1; f < 3; f++)
      begin
        wr(8'h01, {2'b10, m[1:0], f[1:0], 2'b00});
        st(3, {5'h02, m[1:0], 1'(m == 0 || f == 2)});
      end
    wr(8'h01, 8'hFC);
    rd(8'h01, 8'hFC);
    st(3, 8'h15);
    $display("test margin done");
    @(posedge sys_clk) slow <= 1'b1;
    wr(8'h01, 8'h68);
    st(2, 8'h0D);
    st(16, 8'h05);
    wr(8'h01, 8'h88);
    st(3, 8'h11);
    wr(8'h01, 8'h08);
    st(3, 8'h01);
    wr(8'h01, 8'h88);
    @(posedge sys_clk) slow <= 1'b0;
    enable_pin <= 1'b0;
    st(4, 8'h09);
    st(8, 8'h01);
    @(posedge sys_clk) enable_pin <= 1'b1;
    st(4, 8'h11);
    wr(8'h02, 8'h1F);
    @(posedge sys_clk) enable_pin <= 1'b0;
    st(4, 8'h01);
    $display("test shutdown done");
    wr(8'h02, 8'h1C);
    st(4, 8'h11);
    @(posedge sys_clk) enable_pin <= 1'b1;
    st(4, 8'h09);
    st(8, 8'h01);
    wr(8'h02, 8'h10);
    st(4, 8'h11);
    wr(8'h01, 8'h08);
    st(3, 8'h11);
    wr(8'h02, 8'h18);
    st(3, 8'h01);
    wr(8'h02, 8'h00);
    st(3, 8'h11);
    @(posedge sys_clk) power_present <= 1'b0;
    st(5, 8'h01);
    @(posedge sys_clk) power_present <= 1'b1;
    st(5, 8'h11);
    cmp_out(n_fast[7:0], 8'h04);
    cmp_out(n_soft[7:0], 8'h03);
    cmp_out(8'(expq.size()), 8'h00);
    $display("test config done");
    stop_test;
  end
endmodule // tb
